// ---- temp_sensor_cfg_irq_limits.sv ----
// Temperature sensor configuration, limit compare and in-band interrupt logic
//
// Operation
// - Sensor control bit 0: 0 keeps conversions running, 1 turns it off.
// - Sensor off blocks new conversions; a running one finishes first.
// - Writing one to clear bit 7 clears irq, event and error status.
// - Writing zero to clear bit changes nothing; the bit reads zero.
// - Error enable bit 4 lets any logged error request an in-band interrupt.
// - Error enable changes only on ENEC, DISEC, RSTDAA or bus reset.
// - Register writes or DEVCTRL never modify the error enable bit.
// - Bit 3 enables interrupt from critical-cold flag; resets to zero.
// - Bit 2 enables interrupt from critical-hot flag; resets to zero.
// - Bit 1 enables interrupt from cold flag; resets to zero.
// - Bit 0 enables interrupt from hot flag.
// - Hot flag sets when result exceeds the hot threshold pair.
// - Hot threshold bytes reset to 0x70 and 0x03.
// - Cold flag sets when result is below the cold threshold pair.
// - Cold threshold bytes reset to zero.
// - Limit bytes: low bits 1:0 and high bits 7:5 read zero, ignore writes.
// - Temperature flags stay set until a one is written to their clear bit or to clear bit 7.
// - Critical-hot flag sets when result exceeds its threshold pair.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_cfg_irq_limits
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register access from the bus protocol engine
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Common command events from the bus protocol engine
    input  wire logic        ccc_enec_err,
    input  wire logic        ccc_disec_err,
    input  wire logic        ccc_rstdaa,
    input  wire logic        bus_reset_seq,
    // Error events to log
    input  wire logic        pec_error_evt,
    input  wire logic        parity_error_evt,
    // Conversion engine
    input  wire logic        conv_busy,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_result,
    output logic             conv_start_allow,
    output logic             sensor_power_on,
    // In-band interrupt
    output logic             ibi_request,
    input  wire logic        ibi_served
);
    typedef struct packed {
        logic [7:0] sensor_control;
        logic [3:0] irq_cfg;
        logic       error_irq_enable;
        logic [7:0] hot_lsb;
        logic [7:0] hot_msb;
        logic [7:0] cold_lsb;
        logic [7:0] cold_msb;
        logic [7:0] crit_hot_lsb;
        logic [7:0] crit_hot_msb;
        logic [7:0] crit_cold_lsb;
        logic [7:0] crit_cold_msb;
        logic [3:0] temp_flags;
        logic [1:0] error_flags;
        logic       irq_pending;
        logic       powered;
        logic [7:0] rdata;
    } state_s;

    state_s st_q;
    state_s st_d;

    limit_cmp_if hot_if ();
    limit_cmp_if cold_if ();
    limit_cmp_if chot_if ();
    limit_cmp_if ccold_if ();

    limit_cmp u_hot   (.c(hot_if));
    limit_cmp u_cold  (.c(cold_if));
    limit_cmp u_chot  (.c(chot_if));
    limit_cmp u_ccold (.c(ccold_if));

    // Each pair as one value, high byte above low byte
    assign hot_if.temp    = conv_result;
    assign hot_if.limit   = {st_q.hot_msb, st_q.hot_lsb};
    assign cold_if.temp   = conv_result;
    assign cold_if.limit  = {st_q.cold_msb, st_q.cold_lsb};
    assign chot_if.temp   = conv_result;
    assign chot_if.limit  = {st_q.crit_hot_msb, st_q.crit_hot_lsb};
    assign ccold_if.temp  = conv_result;
    assign ccold_if.limit = {st_q.crit_cold_msb, st_q.crit_cold_lsb};

    logic       wr_hit;
    logic       clear_all;
    logic [3:0] temp_set;
    logic [3:0] temp_clr;
    logic [1:0] err_set;
    logic [1:0] err_clr;
    logic       irq_cause;
    logic [7:0] rd_mux;

    always_comb
    begin
        st_d      = st_q;
        wr_hit    = reg_wr;
        clear_all = wr_hit && reg_addr == tsens_pkg::OFS_INTERRUPT_CONFIG
                    && reg_wdata[tsens_pkg::BIT_CLEAR_ALL_EVENTS];
        temp_clr  = 4'h0;
        err_clr   = 2'h0;
        temp_set  = 4'h0;
        err_set   = {pec_error_evt, parity_error_evt};

        // Compare only when a fresh result lands
        if (conv_done)
        begin
            temp_set[0] = hot_if.above;
            temp_set[1] = cold_if.below;
            temp_set[2] = chot_if.above;
            temp_set[3] = ccold_if.below;
        end

        if (wr_hit)
        begin
            case (reg_addr)
                tsens_pkg::OFS_SENSOR_CONTROL:
                    st_d.sensor_control = {7'h00,
                        reg_wdata[tsens_pkg::BIT_SENSOR_OFF]};
                tsens_pkg::OFS_INTERRUPT_CONFIG:
                    // Error enable bit is not touched by this path
                    st_d.irq_cfg = reg_wdata[3:0]
                        & tsens_pkg::MASK_IRQ_CFG_RW[3:0];
                tsens_pkg::OFS_HOT_LSB:
                    st_d.hot_lsb = reg_wdata & tsens_pkg::MASK_LIMIT_LSB;
                tsens_pkg::OFS_HOT_MSB:
                    st_d.hot_msb = reg_wdata & tsens_pkg::MASK_LIMIT_MSB;
                tsens_pkg::OFS_COLD_LSB:
                    st_d.cold_lsb = reg_wdata & tsens_pkg::MASK_LIMIT_LSB;
                tsens_pkg::OFS_COLD_MSB:
                    st_d.cold_msb = reg_wdata & tsens_pkg::MASK_LIMIT_MSB;
                tsens_pkg::OFS_CRIT_HOT_LSB:
                    st_d.crit_hot_lsb = reg_wdata & tsens_pkg::MASK_LIMIT_LSB;
                tsens_pkg::OFS_CRIT_HOT_MSB:
                    st_d.crit_hot_msb = reg_wdata & tsens_pkg::MASK_LIMIT_MSB;
                tsens_pkg::OFS_CRIT_COLD_LSB:
                    st_d.crit_cold_lsb = reg_wdata & tsens_pkg::MASK_LIMIT_LSB;
                tsens_pkg::OFS_CRIT_COLD_MSB:
                    st_d.crit_cold_msb = reg_wdata & tsens_pkg::MASK_LIMIT_MSB;
                tsens_pkg::OFS_TEMP_CLEAR:
                    temp_clr = reg_wdata[3:0];
                tsens_pkg::OFS_ERROR_CLEAR:
                    err_clr = reg_wdata[1:0];
                default:
                    st_d.rdata = st_q.rdata;
            endcase
        end

        // Error enable moves only on common commands or bus reset
        if (ccc_rstdaa || bus_reset_seq || ccc_disec_err)
            st_d.error_irq_enable = 1'b0;
        else if (ccc_enec_err)
            st_d.error_irq_enable = 1'b1;

        // Set wins over any clear in the same cycle; zero writes do nothing
        if (clear_all)
        begin
            temp_clr = 4'hF;
            err_clr  = 2'h3;
        end
        st_d.temp_flags  = (st_q.temp_flags & ~temp_clr) | temp_set;
        st_d.error_flags = (st_q.error_flags & ~err_clr) | err_set;

        irq_cause = |(st_d.temp_flags & st_q.irq_cfg)
                    || (st_q.error_irq_enable && |st_d.error_flags);
        // Pending holds until served, globally cleared or its cause goes away
        if (clear_all || !irq_cause)
            st_d.irq_pending = 1'b0;
        else if (ibi_served)
            st_d.irq_pending = 1'b0;
        else if (|temp_set || |err_set || !st_q.irq_pending)
            st_d.irq_pending = 1'b1;

        // Sensor powers down only once no conversion is in flight
        if (!st_q.sensor_control[tsens_pkg::BIT_SENSOR_OFF])
            st_d.powered = 1'b1;
        else if (!conv_busy)
            st_d.powered = 1'b0;

        case (reg_addr)
            tsens_pkg::OFS_SENSOR_CONTROL:    rd_mux = st_q.sensor_control;
            tsens_pkg::OFS_INTERRUPT_CONFIG:
                rd_mux = {3'b000, st_q.error_irq_enable, st_q.irq_cfg};
            tsens_pkg::OFS_HOT_LSB:           rd_mux = st_q.hot_lsb;
            tsens_pkg::OFS_HOT_MSB:           rd_mux = st_q.hot_msb;
            tsens_pkg::OFS_COLD_LSB:          rd_mux = st_q.cold_lsb;
            tsens_pkg::OFS_COLD_MSB:          rd_mux = st_q.cold_msb;
            tsens_pkg::OFS_CRIT_HOT_LSB:      rd_mux = st_q.crit_hot_lsb;
            tsens_pkg::OFS_CRIT_HOT_MSB:      rd_mux = st_q.crit_hot_msb;
            tsens_pkg::OFS_CRIT_COLD_LSB:     rd_mux = st_q.crit_cold_lsb;
            tsens_pkg::OFS_CRIT_COLD_MSB:     rd_mux = st_q.crit_cold_msb;
            tsens_pkg::OFS_IRQ_STATUS:
                rd_mux = {st_q.irq_pending, 7'h00};
            tsens_pkg::OFS_TEMP_EVENT_STATUS: rd_mux = {4'h0, st_q.temp_flags};
            tsens_pkg::OFS_ERROR_STATUS:
                rd_mux = {6'h00, st_q.error_flags};
            default:                          rd_mux = 8'h00;
        endcase
        if (reg_rd)
            st_d.rdata = rd_mux;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q                  <= '0;
            st_q.sensor_control   <= tsens_pkg::RST_SENSOR_CONTROL;
            st_q.irq_cfg          <= tsens_pkg::RST_IRQ_CONFIG[3:0];
            st_q.hot_lsb          <= tsens_pkg::RST_HOT_LSB;
            st_q.hot_msb          <= tsens_pkg::RST_HOT_MSB;
            st_q.cold_lsb         <= tsens_pkg::RST_COLD_LSB;
            st_q.cold_msb         <= tsens_pkg::RST_COLD_MSB;
            st_q.crit_hot_lsb     <= tsens_pkg::RST_CRIT_HOT_LSB;
            st_q.crit_hot_msb     <= tsens_pkg::RST_CRIT_HOT_MSB;
            st_q.crit_cold_lsb    <= tsens_pkg::RST_CRIT_COLD_LSB;
            st_q.crit_cold_msb    <= tsens_pkg::RST_CRIT_COLD_MSB;
            st_q.powered          <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Host ordering of critical vs plain thresholds is trusted, not checked
    assign conv_start_allow =
        !st_q.sensor_control[tsens_pkg::BIT_SENSOR_OFF];
    assign sensor_power_on  = st_q.powered;
    assign ibi_request      = st_q.irq_pending;
    assign reg_rdata        = st_q.rdata;
endmodule // temp_sensor_cfg_irq_limits
`default_nettype wire

// ---- tsens_pkg.sv ----
// Package: register offsets, field positions, reset values for the sensor block
package tsens_pkg;
    localparam logic [7:0] OFS_SENSOR_CONTROL       = 8'h1A;
    localparam logic [7:0] OFS_INTERRUPT_CONFIG     = 8'h1B;
    localparam logic [7:0] OFS_HOT_LSB              = 8'h1C;
    localparam logic [7:0] OFS_HOT_MSB              = 8'h1D;
    localparam logic [7:0] OFS_COLD_LSB             = 8'h1E;
    localparam logic [7:0] OFS_COLD_MSB             = 8'h1F;
    localparam logic [7:0] OFS_CRIT_HOT_LSB         = 8'h20;
    localparam logic [7:0] OFS_CRIT_HOT_MSB         = 8'h21;
    localparam logic [7:0] OFS_CRIT_COLD_LSB        = 8'h22;
    localparam logic [7:0] OFS_CRIT_COLD_MSB        = 8'h23;
    localparam logic [7:0] OFS_TEMP_CLEAR           = 8'h13;
    localparam logic [7:0] OFS_ERROR_CLEAR          = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS           = 8'h30;
    localparam logic [7:0] OFS_TEMP_EVENT_STATUS    = 8'h33;
    localparam logic [7:0] OFS_ERROR_STATUS         = 8'h34;

    localparam int BIT_SENSOR_OFF        = 0;
    localparam int BIT_CLEAR_ALL_EVENTS  = 7;
    localparam int BIT_ERROR_IRQ_ENABLE  = 4;
    localparam int BIT_CRIT_COLD_ENABLE  = 3;
    localparam int BIT_CRIT_HOT_ENABLE   = 2;
    localparam int BIT_COLD_ENABLE       = 1;
    localparam int BIT_HOT_ENABLE        = 0;
    localparam int BIT_IRQ_PENDING       = 7;

    // Writable masks: low bytes drop bits 1:0, high bytes drop bits 7:5
    localparam logic [7:0] MASK_LIMIT_LSB = 8'hFC;
    localparam logic [7:0] MASK_LIMIT_MSB = 8'h1F;
    localparam logic [7:0] MASK_IRQ_CFG_RW = 8'h0F;

    localparam logic [7:0] RST_SENSOR_CONTROL = 8'h00;
    localparam logic [7:0] RST_IRQ_CONFIG     = 8'h00;
    localparam logic [7:0] RST_HOT_LSB        = 8'h70;
    localparam logic [7:0] RST_HOT_MSB        = 8'h03;
    localparam logic [7:0] RST_COLD_LSB       = 8'h00;
    localparam logic [7:0] RST_COLD_MSB       = 8'h00;
    localparam logic [7:0] RST_CRIT_HOT_LSB   = 8'h50;
    localparam logic [7:0] RST_CRIT_HOT_MSB   = 8'h05;
    localparam logic [7:0] RST_CRIT_COLD_LSB  = 8'h00;
    localparam logic [7:0] RST_CRIT_COLD_MSB  = 8'h00;
endpackage : tsens_pkg

// ---- limit_cmp_if.sv ----
// Interface: one threshold comparison between main block and comparator
`timescale 1ns/1ps
`default_nettype none
interface limit_cmp_if;
    logic [15:0] temp;
    logic [15:0] limit;
    logic        above;
    logic        below;
    modport owner (output temp, output limit, input above, input below);
    modport cmp   (input temp, input limit, output above, output below);
endinterface : limit_cmp_if
`default_nettype wire

// ---- limit_cmp.sv ----
// Signed comparison of a 13-bit temperature against one threshold pair
`timescale 1ns/1ps
`default_nettype none
module limit_cmp
(
    limit_cmp_if.cmp c
);
    // Both values are two's complement in quarter degrees, sign at bit 12
    logic signed [12:0] t_s;
    logic signed [12:0] l_s;

    assign t_s     = $signed(c.temp[12:0]);
    assign l_s     = $signed(c.limit[12:0]);
    assign c.above = t_s > l_s;
    assign c.below = t_s < l_s;
endmodule // limit_cmp
`default_nettype wire

// ---- tsens_props.sv ----
// Checker: port-level properties of the sensor configuration block
`timescale 1ns/1ps
`default_nettype none
module tsens_props
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Register bus
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Events, conversion and interrupt
    input wire logic       pec_error_evt,
    input wire logic       parity_error_evt,
    input wire logic       conv_busy,
    input wire logic       conv_done,
    input wire logic       conv_start_allow,
    input wire logic       sensor_power_on,
    input wire logic       ibi_request,
    input wire logic       ibi_served
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_quiet;
        !conv_done && !pec_error_evt && !parity_error_evt;
    endsequence
    // A new event in the same cycle would win over the clear
    sequence s_gclr;
        reg_wr && reg_addr == 8'h1B && reg_wdata[7] ##0 s_quiet;
    endsequence
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    AST_SENSOR_OFF: assert property (
        reg_wr && reg_addr == 8'h1A && reg_wdata[0] |-> ##[1:2] !conv_start_allow)
        else $error("conversion start still allowed after sensor off");
    AST_BUSY_KEEPS_POWER: assert property (
        conv_busy && sensor_power_on |=> sensor_power_on)
        else $error("sensor powered down during a conversion");
    AST_CTRL_RESERVED: assert property (
        s_rd(8'h1A) |=> reg_rdata[7:1] == 7'h00)
        else $error("control reserved bits read nonzero");
    AST_CLEAR_READS_ZERO: assert property (
        s_rd(8'h1B) |=> reg_rdata[7:5] == 3'h0)
        else $error("clear bit read back nonzero");
    AST_LSB_MASK: assert property (
        (s_rd(8'h1C) or s_rd(8'h1E)) |=> reg_rdata[1:0] == 2'h0)
        else $error("limit low byte bits 1:0 nonzero");
    AST_MSB_MASK: assert property (
        (s_rd(8'h1D) or s_rd(8'h1F)) |=> reg_rdata[7:5] == 3'h0)
        else $error("limit high byte bits 7:5 nonzero");
    AST_RDATA_HOLDS: assert property (
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_SERVED_DROPS: assert property (
        ibi_served |=> !ibi_request)
        else $error("interrupt request held after service");
    AST_GLOBAL_CLEAR: assert property (
        s_gclr ##1 s_quiet |=> !ibi_request)
        else $error("interrupt request survived global clear");
endmodule // tsens_props
bind temp_sensor_cfg_irq_limits tsens_props i_tsens_props (.clk, .srst,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .pec_error_evt,
    .parity_error_evt, .conv_busy, .conv_done, .conv_start_allow,
    .sensor_power_on, .ibi_request, .ibi_served);
`default_nettype wire

// ---- ibi_host_model.sv ----
// Host controller model: serves pending in-band interrupts
`timescale 1ns/1ps
`default_nettype none
module ibi_host_model
#(
    parameter int WAIT = 3
)
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Interrupt handshake
    input  wire logic serve_en,
    input  wire logic ibi_request,
    output var  logic ibi_served
);
    int cnt;
    // One pulse per request; a slow host lets it pend WAIT+2 cycles
    always_ff @(posedge clk)
    begin
        if (srst || !ibi_request || ibi_served)
        begin
            cnt        <= 0;
            ibi_served <= 1'b0;
        end
        else
        begin
            cnt        <= cnt + 1;
            ibi_served <= serve_en && cnt >= WAIT;
        end
    end
endmodule // ibi_host_model
`default_nettype wire

// ---- temp_sensor_cfg_irq_limits_bench.sv ----
// Testbench: self-checking scenarios for the sensor configuration block
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_cfg_irq_limits_bench;
    logic        clk, srst, reg_wr, reg_rd, busy, done, serve_en;
    logic        allow, pwr, ibi, served;
    logic [7:0]  addr, wdata, rdata;
    logic [15:0] result;
    logic [5:0]  ev;
    int          n_fail, checks_done;
    temp_sensor_cfg_irq_limits i_temp_sensor_cfg_irq_limits (.clk(clk),
        .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .ccc_enec_err(ev[5]),
        .ccc_disec_err(ev[2]), .ccc_rstdaa(ev[3]), .bus_reset_seq(ev[4]),
        .pec_error_evt(ev[1]), .parity_error_evt(ev[0]), .conv_busy(busy),
        .conv_done(done), .conv_result(result), .conv_start_allow(allow),
        .sensor_power_on(pwr), .ibi_request(ibi), .ibi_served(served));
    ibi_host_model i_ibi_host_model (.clk(clk), .srst(srst),
        .serve_en(serve_en), .ibi_request(ibi), .ibi_served(served));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // An idle edge after each strobe keeps back-to-back calls apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_wr, addr, wdata} = {1'b1, a, d};
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        {reg_rd, addr} = {1'b1, a};
        cyc(1);
        reg_rd = 1'b0;
        chk(rdata, e);
        cyc(1);
    endtask
    task automatic pulse(input logic [5:0] v);
        ev = v;
        cyc(1);
        ev = 6'h00;
    endtask
    // Leaves time for flag set and the registered request
    task automatic conv(input logic [15:0] r);
        {done, result} = {1'b1, r};
        cyc(1);
        done = 1'b0;
        cyc(2);
    endtask
    task automatic t_reset_vals;
        logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h70, 8'h03, 8'h00, 8'h00};
        chk({5'h00, allow, pwr, ibi}, 8'h06);
        for (int i = 0; i < 6; i++)
            rd(8'h1A + i[7:0], rv[i]);
    endtask
    task automatic t_masks;
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h1C + i[7:0], 8'hFF);
            rd(8'h1C + i[7:0], i[0] ? 8'h1F : 8'hFC);
        end
        wr(8'h1A, 8'hFF);
        rd(8'h1A, 8'h01);
        wr(8'h1A, 8'h00);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'h0F);
        wr(8'h1C, 8'h70);
        wr(8'h1D, 8'h03);
        wr(8'h1F, 8'h00);
        wr(8'h1E, 8'h10);
    endtask
    task automatic t_enables;
        logic [15:0] hit [4] = '{16'h0400, 16'h0008, 16'h0600, 16'h1FFC};
        logic [15:0] miss [4] = '{16'h1FFC, 16'h0400, 16'h0400, 16'h0008};
        logic [7:0]  fl [4] = '{8'h01, 8'h02, 8'h05, 8'h0A};
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h1B, 8'h80 | (8'h01 << i));
            conv(miss[i]);
            chk({7'h00, ibi}, 8'h00);
            wr(8'h1B, 8'h80 | (8'h01 << i));
            conv(hit[i]);
            chk({7'h00, ibi}, 8'h01);
            rd(8'h33, fl[i]);
            wr(8'h13, fl[i]);
            rd(8'h33, 8'h00);
        end
        wr(8'h1B, 8'h83);
        conv(16'h0370);
        conv(16'h0010);
        rd(8'h33, 8'h00);
    endtask
    task automatic t_clear;
        conv(16'h0400);
        conv(16'h0008);
        wr(8'h13, 8'h00);
        rd(8'h33, 8'h03);
        wr(8'h1B, 8'h03);
        rd(8'h33, 8'h03);
        wr(8'h13, 8'h01);
        rd(8'h33, 8'h02);
        chk({7'h00, ibi}, 8'h01);
        wr(8'h1B, 8'h83);
        rd(8'h33, 8'h00);
        rd(8'h30, 8'h00);
        chk({7'h00, ibi}, 8'h00);
    endtask
    task automatic t_errors;
        wr(8'h1B, 8'h80);
        for (int k = 0; k < 3; k++)
        begin
            pulse(k == 1 ? 6'h01 : 6'h02);
            cyc(2);
            chk({7'h00, ibi}, 8'h00);
            rd(8'h34, k == 1 ? 8'h01 : 8'h02);
            pulse(6'h20);
            rd(8'h1B, 8'h10);
            cyc(1);
            chk({7'h00, ibi}, 8'h01);
            wr(8'h1B, 8'h00);
            rd(8'h1B, 8'h10);
            pulse(6'h04 << k);
            rd(8'h1B, 8'h00);
            wr(8'h1B, 8'h80);
            rd(8'h34, 8'h00);
        end
        pulse(6'h03);
        wr(8'h14, 8'h00);
        rd(8'h34, 8'h03);
        wr(8'h14, 8'h01);
        rd(8'h34, 8'h02);
        wr(8'h14, 8'h02);
        rd(8'h34, 8'h00);
    endtask
    task automatic t_served;
        wr(8'h1B, 8'h81);
        conv(16'h0400);
        serve_en = 1'b1;
        for (int n = 0; n < 20 && served !== 1'b1; n++)
            cyc(1);
        serve_en = 1'b0;
        chk({7'h00, served}, 8'h01);
        cyc(1);
        chk({7'h00, ibi}, 8'h00);
        wr(8'h1B, 8'h80);
    endtask
    task automatic t_power;
        busy = 1'b1;
        wr(8'h1A, 8'h01);
        cyc(2);
        chk({6'h00, allow, pwr}, 8'h01);
        busy = 1'b0;
        cyc(2);
        chk({6'h00, allow, pwr}, 8'h00);
        wr(8'h1A, 8'h00);
        cyc(2);
        chk({7'h00, allow}, 8'h01);
    endtask
    // Reset in mid-run must restore every register and flag
    task automatic t_mid_reset;
        wr(8'h1A, 8'h01);
        wr(8'h1C, 8'hFF);
        pulse(6'h20);
        conv(16'h0400);
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        t_reset_vals;
        rd(8'h33, 8'h00);
        rd(8'h34, 8'h00);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {srst, reg_wr, reg_rd, busy, done, serve_en} = 6'h20;
        {addr, wdata, result, ev} = '0;
        cyc(6);
        srst = 1'b0;
        t_reset_vals;
        t_masks;
        t_enables;
        t_clear;
        t_errors;
        t_served;
        t_power;
        t_mid_reset;
        test_done;
    end
    // The run needs well under a thousand cycles; ten thousand means a hang
    initial
    begin
        #100000;
        n_fail++;
        test_done;
    end
endmodule // temp_sensor_cfg_irq_limits_bench
`default_nettype wire
